// ===== rtl/fpio_pkg.sv
package fpio_pkg;
   // Register byte offsets on the AXI4-Lite bus
   localparam logic [5:0] ADDR_P1_LATCH = 6'h00;
   localparam logic [5:0] ADDR_P1_DIR = 6'h04;
   localparam logic [5:0] ADDR_P2_LATCH = 6'h08;
   localparam logic [5:0] ADDR_P2_DIR = 6'h0c;
   localparam logic [5:0] ADDR_P3_LATCH = 6'h10;
   localparam logic [5:0] ADDR_P3_DIR = 6'h14;
   localparam logic [5:0] ADDR_P4_LATCH = 6'h18;
   localparam logic [5:0] ADDR_P4_DIR = 6'h1c;
   localparam logic [5:0] ADDR_P5_LATCH = 6'h20;
   localparam logic [5:0] ADDR_P5_DIR = 6'h24;
   localparam logic [5:0] ADDR_P5_ANALOG = 6'h28;
   localparam logic [5:0] ADDR_PIN_COUNT = 6'h2c;
   // Implemented-bit masks per port
   localparam logic [7:0] MASK_P1 = 8'hff;
   localparam logic [7:0] MASK_P2 = 8'hff;
   localparam logic [7:0] MASK_P3_FULL = 8'hef;
   localparam logic [7:0] MASK_P3_SMALL = 8'h8f;
   localparam logic [7:0] MASK_P4 = 8'h1f;
   localparam logic [7:0] MASK_P5 = 8'hff;
   // Reset values: all pins input, latches clear, analog blocked
   localparam logic [7:0] RESET_LATCH = 8'h00;
   localparam logic [7:0] RESET_DIR = 8'h00;
   localparam logic [7:0] RESET_ANALOG = 8'h00;
   // Port and pin totals
   localparam int NUM_PORTS = 5;
   localparam logic [7:0] PIN_TOTAL = 8'h22;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== rtl/fpio_sync.sv
`timescale 1ns/100ps
// Three-stage pin synchroniser; level accepted when stages two and three agree
module fpio_sync #(
   parameter int WIDTH = 8
) (
   // Clock and control
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clk_en,
   // Data
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } fpio_sync_t;
   fpio_sync_t st;
   fpio_sync_t next_st;

   // Shift chain and agreement filter
   always_comb begin
      next_st = st;
      next_st.s1 = pin_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            next_st.lvl[i] = st.s3[i];
         end
      end
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         st <= '0;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   assign level = st.lvl;
endmodule

// ===== rtl/fpio_port.sv
`timescale 1ns/100ps
// One parallel port: latch, direction, pin drive and readback
module fpio_port #(
   parameter logic [7:0] MASK = 8'hff
) (
   // Clock and control
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clk_en,
   // Register writes
   input wire logic latch_we,
   input wire logic dir_we,
   input wire logic [7:0] wdata,
   // Pins
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   // Readback
   output logic [7:0] latch,
   output logic [7:0] dir,
   output logic [7:0] read_val
);
   typedef struct packed {
      logic [7:0] latch;
      logic [7:0] dir;
      logic [7:0] out;
      logic [7:0] oe;
   } fpio_port_t;
   fpio_port_t st;
   fpio_port_t next_st;
   logic [7:0] level;

   // Pin input synchroniser
   fpio_sync #(.WIDTH(8)) u_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .pin_in(pin_in),
      .level(level)
   );

   // Register update and pin drive, unimplemented bits held at zero
   always_comb begin
      next_st = st;
      if (latch_we) begin
         next_st.latch = wdata & MASK;
      end
      if (dir_we) begin
         next_st.dir = wdata & MASK;
      end
      next_st.out = next_st.latch & next_st.dir;
      next_st.oe = next_st.dir;
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         st.latch <= fpio_pkg::RESET_LATCH;
         st.dir <= fpio_pkg::RESET_DIR;
         st.out <= 8'h00;
         st.oe <= 8'h00;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   assign pin_out = st.out;
   assign pin_oe = st.oe;
   assign latch = st.latch;
   assign dir = st.dir;
   assign read_val = ((st.dir & st.latch) | (~st.dir & level)) & MASK;
endmodule

// ===== rtl/fpio_top.sv
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
// Summary of operation
// - Five ports, thirty-six pins (thirty-four on the small variant), shared functions
// - Output drives latch; input pin readable
// - One direction bit per pin
// - Port 1 eight bits to pins
// - Port 2 eight bits to pins
// - Port 3 bit 4 has no pin
// - Small variant: port 3 bits 5,6 absent
// - Port 4 only bits 4..0
// - Port 5 data, direction, analog enable
// - Analog enable gates each port 5 pin
// - Pins shareable with peripheral functions
module fpio_top #(
   parameter bit SMALL_VARIANT = 1'b0
) (
   // Clock, reset and enable
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clk_en,
   // AXI4-Lite write address
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Port pins, five ports of eight lanes
   input wire logic [39:0] pin_in,
   output logic [39:0] pin_out,
   output logic [39:0] pin_oe,
   // Port 5 analog input permit per pin
   output logic [7:0] analog_input_permit
);
   localparam logic [7:0] MASK_P3 = SMALL_VARIANT ? fpio_pkg::MASK_P3_SMALL : fpio_pkg::MASK_P3_FULL;

   typedef struct packed {
      logic aw_full;
      logic [5:0] aw_addr;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] analog;
      logic awready;
      logic wready;
      logic arready;
   } fpio_top_t;
   fpio_top_t st;
   fpio_top_t next_st;

   logic [4:0] latch_we;
   logic [4:0] dir_we;
   logic [39:0] dir_all;
   logic [39:0] read_all;
   logic [39:0] port_out;
   logic [39:0] port_oe;
   logic wr_go;
   logic wr_ok;
   logic [7:0] wbyte;

   fpio_port #(.MASK(fpio_pkg::MASK_P1)) u_port1 (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .latch_we(latch_we[0]),
      .dir_we(dir_we[0]),
      .wdata(wbyte),
      .pin_in(pin_in[7:0]),
      .pin_out(port_out[7:0]),
      .pin_oe(port_oe[7:0]),
      .latch(),
      .dir(dir_all[7:0]),
      .read_val(read_all[7:0])
   );

   fpio_port #(.MASK(fpio_pkg::MASK_P2)) u_port2 (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .latch_we(latch_we[1]),
      .dir_we(dir_we[1]),
      .wdata(wbyte),
      .pin_in(pin_in[15:8]),
      .pin_out(port_out[15:8]),
      .pin_oe(port_oe[15:8]),
      .latch(),
      .dir(dir_all[15:8]),
      .read_val(read_all[15:8])
   );

   fpio_port #(.MASK(MASK_P3)) u_port3 (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .latch_we(latch_we[2]),
      .dir_we(dir_we[2]),
      .wdata(wbyte),
      .pin_in(pin_in[23:16]),
      .pin_out(port_out[23:16]),
      .pin_oe(port_oe[23:16]),
      .latch(),
      .dir(dir_all[23:16]),
      .read_val(read_all[23:16])
   );

   fpio_port #(.MASK(fpio_pkg::MASK_P4)) u_port4 (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .latch_we(latch_we[3]),
      .dir_we(dir_we[3]),
      .wdata(wbyte),
      .pin_in(pin_in[31:24]),
      .pin_out(port_out[31:24]),
      .pin_oe(port_oe[31:24]),
      .latch(),
      .dir(dir_all[31:24]),
      .read_val(read_all[31:24])
   );

   fpio_port #(.MASK(fpio_pkg::MASK_P5)) u_port5 (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .latch_we(latch_we[4]),
      .dir_we(dir_we[4]),
      .wdata(wbyte),
      .pin_in(pin_in[39:32]),
      .pin_out(port_out[39:32]),
      .pin_oe(port_oe[39:32]),
      .latch(),
      .dir(dir_all[39:32]),
      .read_val(read_all[39:32])
   );

   // pins free for sharing
   // Port outputs are already masked flip-flops
   assign pin_out = port_out;
   assign pin_oe = port_oe;

   // Write is performed when address and data are both held and response free
   assign wr_go = st.aw_full && st.w_full && !st.bvalid;
   assign wr_ok = st.w_strb[0];
   assign wbyte = st.w_data[7:0];

   // Write address decode into per-port strobes
   always_comb begin
      latch_we = 5'h00;
      dir_we = 5'h00;
      if (wr_go && wr_ok) begin
         if (st.aw_addr == fpio_pkg::ADDR_P1_LATCH) begin
            latch_we[0] = 1'b1;
         end else if (st.aw_addr == fpio_pkg::ADDR_P1_DIR) begin
            dir_we[0] = 1'b1;
         end else if (st.aw_addr == fpio_pkg::ADDR_P2_LATCH) begin
            latch_we[1] = 1'b1;
         end else if (st.aw_addr == fpio_pkg::ADDR_P2_DIR) begin
            dir_we[1] = 1'b1;
         end else if (st.aw_addr == fpio_pkg::ADDR_P3_LATCH) begin
            latch_we[2] = 1'b1;
         end else if (st.aw_addr == fpio_pkg::ADDR_P3_DIR) begin
            dir_we[2] = 1'b1;
         end else if (st.aw_addr == fpio_pkg::ADDR_P4_LATCH) begin
            latch_we[3] = 1'b1;
         end else if (st.aw_addr == fpio_pkg::ADDR_P4_DIR) begin
            dir_we[3] = 1'b1;
         end else if (st.aw_addr == fpio_pkg::ADDR_P5_LATCH) begin
            latch_we[4] = 1'b1;
         end else if (st.aw_addr == fpio_pkg::ADDR_P5_DIR) begin
            dir_we[4] = 1'b1;
         end
      end
   end

   // Bus channel handling and register file
   always_comb begin
      logic mapped_w;
      logic [31:0] rd;
      logic hit;
      mapped_w = 1'b0;
      rd = 32'h0000_0000;
      hit = 1'b1;
      next_st = st;
      // Capture address and data independently
      if (s_axi_awvalid && !st.aw_full) begin
         next_st.aw_full = 1'b1;
         next_st.aw_addr = {s_axi_awaddr[5:2], 2'h0};
      end
      if (s_axi_wvalid && !st.w_full) begin
         next_st.w_full = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
      end
      if (wr_go) begin
         mapped_w = (st.aw_addr <= fpio_pkg::ADDR_P5_ANALOG) || (st.aw_addr == fpio_pkg::ADDR_PIN_COUNT);
         if (st.aw_addr == fpio_pkg::ADDR_P5_ANALOG && wr_ok) begin
            next_st.analog = wbyte & fpio_pkg::MASK_P5;
         end
         next_st.aw_full = 1'b0;
         next_st.w_full = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = mapped_w ? fpio_pkg::RESP_OKAY : fpio_pkg::RESP_SLVERR;
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      // Read decode
      if (s_axi_arvalid && !st.rvalid) begin
         if ({s_axi_araddr[5:2], 2'h0} == fpio_pkg::ADDR_P1_LATCH) begin
            rd[7:0] = read_all[7:0];
         end else if ({s_axi_araddr[5:2], 2'h0} == fpio_pkg::ADDR_P1_DIR) begin
            rd[7:0] = dir_all[7:0];
         end else if ({s_axi_araddr[5:2], 2'h0} == fpio_pkg::ADDR_P2_LATCH) begin
            rd[7:0] = read_all[15:8];
         end else if ({s_axi_araddr[5:2], 2'h0} == fpio_pkg::ADDR_P2_DIR) begin
            rd[7:0] = dir_all[15:8];
         end else if ({s_axi_araddr[5:2], 2'h0} == fpio_pkg::ADDR_P3_LATCH) begin
            rd[7:0] = read_all[23:16];
         end else if ({s_axi_araddr[5:2], 2'h0} == fpio_pkg::ADDR_P3_DIR) begin
            rd[7:0] = dir_all[23:16];
         end else if ({s_axi_araddr[5:2], 2'h0} == fpio_pkg::ADDR_P4_LATCH) begin
            rd[7:0] = read_all[31:24];
         end else if ({s_axi_araddr[5:2], 2'h0} == fpio_pkg::ADDR_P4_DIR) begin
            rd[7:0] = dir_all[31:24];
         end else if ({s_axi_araddr[5:2], 2'h0} == fpio_pkg::ADDR_P5_LATCH) begin
            rd[7:0] = read_all[39:32];
         end else if ({s_axi_araddr[5:2], 2'h0} == fpio_pkg::ADDR_P5_DIR) begin
            rd[7:0] = dir_all[39:32];
         end else if ({s_axi_araddr[5:2], 2'h0} == fpio_pkg::ADDR_P5_ANALOG) begin
            rd[7:0] = st.analog;
         end else if ({s_axi_araddr[5:2], 2'h0} == fpio_pkg::ADDR_PIN_COUNT) begin
            // Usable pin count, read only
            rd[7:0] = SMALL_VARIANT ? fpio_pkg::PIN_TOTAL : fpio_pkg::PIN_TOTAL + 8'h02;
         end else begin
            hit = 1'b0;
         end
         next_st.rvalid = 1'b1;
         next_st.rdata = rd;
         next_st.rresp = hit ? fpio_pkg::RESP_OKAY : fpio_pkg::RESP_SLVERR;
      end else if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      // Ready flags kept in flip-flops, high while the holding slot is free
      next_st.awready = !next_st.aw_full;
      next_st.wready = !next_st.w_full;
      next_st.arready = !next_st.rvalid;
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         st <= '0;
         st.analog <= fpio_pkg::RESET_ANALOG;
         st.awready <= 1'b1;
         st.wready <= 1'b1;
         st.arready <= 1'b1;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   // Bus outputs from flip-flops; ready reflects empty holding slot
   assign s_axi_awready = st.awready;
   assign s_axi_wready = st.wready;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;
   assign analog_input_permit = st.analog;
endmodule

// ===== tb/fpio_pin_model.sv
`timescale 1ns/100ps
// Outside world at the pins: resolves each lane from the design's enable
module fpio_pin_model (
   // Design pin side
   input wire logic [39:0] pin_out,
   input wire logic [39:0] pin_oe,
   // Level outside circuits put on undriven lanes
   input wire logic [39:0] ext_level,
   // Resolved level fed back to the design
   output logic [39:0] pin_in
);
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ===== tb/fpio_checker.sv
`timescale 1ns/100ps
// Watches bus handshakes and pin masking at the top ports
module fpio_checker #(
   parameter bit SMALL_VARIANT = 1'b0
) (
   // Clock and control
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clk_en,
   // Write side
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read side
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins
   input wire logic [39:0] pin_in,
   input wire logic [39:0] pin_out,
   input wire logic [39:0] pin_oe,
   input wire logic [7:0] analog_input_permit
);
   // Lanes without a pin: port 4 top bits, port 3 bit 4, bits 5,6 on the small part
   logic [39:0] nopin;
   assign nopin = {8'h00, 8'he0, (SMALL_VARIANT ? 8'h70 : 8'h10), 16'h0000};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn || !clk_en);
   // Write steps: both channels taken, then answer two edges on
   sequence wr_taken_s;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence wr_answer_s;
      ##2 s_axi_bvalid;
   endsequence
   nopin_quiet_a: assert property (
      ((pin_oe | pin_out) & nopin) == 40'h0) else $error("lane without pin is active");
   out_gated_a: assert property (
      (pin_out & ~pin_oe) == 40'h0) else $error("pin value shown on input lane");
   rd_upper_a: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("read data upper bits set");
   rd_answer_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   rd_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
   wr_answer_a: assert property (
      wr_taken_s |-> wr_answer_s) else $error("write response late");
   b_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   dir_update_a: assert property (
      $changed(pin_oe) |-> $rose(s_axi_bvalid)) else $error("direction changed without write");
endmodule
bind fpio_top fpio_checker #(.SMALL_VARIANT(SMALL_VARIANT)) u_chk (.*);

// ===== tb/tb.sv
`timescale 1ns/100ps
// Register-level test of the five-port parallel block, small variant
module tb;
   logic sys_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1;
   logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [39:0] pin_in, pin_out, pin_oe, ext_level = 40'h0;
   logic [7:0] analog_input_permit;
   logic [7:0] mk [5] = '{8'hff, 8'hff, 8'h8f, 8'h1f, 8'hff};
   int miscompares = 0, n_checks = 0;
   // Clock
   always #5 sys_clk = ~sys_clk;
   fpio_top #(.SMALL_VARIANT(1'b1)) u_dut (.*);
   fpio_pin_model u_pins (.pin_out, .pin_oe, .ext_level, .pin_in);
   // Compare and count
   task automatic check(input logic [39:0] got, input logic [39:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Bounded wait step
   task automatic guard(inout int n);
      n++;
      if (n > 50) begin
         miscompares++;
         $display("[ERR] %0t handshake timeout", $time);
         report_and_stop();
      end
   endtask
   // Wait for a design answer: 0 arready, 1 rvalid, 2 bvalid
   task automatic wait_hi(input int sel);
      int n;
      n = 0;
      @(posedge sys_clk);
      while ((sel == 0 ? s_axi_arready : (sel == 1 ? s_axi_rvalid : s_axi_bvalid)) !== 1'b1) begin
         guard(n);
         @(posedge sys_clk);
      end
   endtask
   // Write with address and data offered together
   task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      bit aw, w;
      n = 0;
      aw = 0;
      w = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge sys_clk);
         if (!aw && s_axi_awready === 1'b1) begin
            aw = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready === 1'b1) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
         guard(n);
      end
      wait_hi(2);
      check(40'(s_axi_bresp), 40'(er));
   endtask
   // Read and compare data and response
   task automatic rdc(input logic [5:0] a, input logic [7:0] exp, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      wait_hi(0);
      s_axi_arvalid <= 1'b0;
      wait_hi(1);
      check(40'(s_axi_rdata), 40'(exp));
      check(40'(s_axi_rresp), 40'(er));
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      for (int p = 0; p < 5; p++) begin
         rdc(6'(8 * p), 8'h00, 2'h0);
         rdc(6'(8 * p + 4), 8'h00, 2'h0);
      end
      rdc(6'h28, 8'h00, 2'h0);
      rdc(6'h2c, 8'h22, 2'h0);
      for (int p = 0; p < 5; p++) begin
         wr(6'(8 * p + 4), 8'hff, 2'h0);
         wr(6'(8 * p), 8'ha5, 2'h0);
         rdc(6'(8 * p), 8'ha5 & mk[p], 2'h0);
         rdc(6'(8 * p + 4), mk[p], 2'h0);
         check(40'(pin_out[8*p+:8]), 40'(8'ha5 & mk[p]));
         wr(6'(8 * p + 4), 8'h0f, 2'h0);
         ext_level[8*p+:8] <= 8'h3c;
         repeat (6) @(posedge sys_clk);
         rdc(6'(8 * p), 8'h05 & mk[p] | 8'h30 & mk[p], 2'h0);
         check(40'(pin_oe[8*p+:8]), 40'(8'h0f & mk[p]));
      end
      wr(6'h28, 8'h81, 2'h0);
      check(40'(analog_input_permit), 40'h81);
      s_axi_wstrb <= 4'h0;
      wr(6'h28, 8'h00, 2'h0);
      s_axi_wstrb <= 4'hf;
      rdc(6'h28, 8'h81, 2'h0);
      wr(6'h2c, 8'hff, 2'h0);
      rdc(6'h2c, 8'h22, 2'h0);
      wr(6'h30, 8'hff, 2'h2);
      rdc(6'h3c, 8'h00, 2'h2);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      check(pin_oe, 40'h0);
      check(pin_out, 40'h0);
      check(40'(analog_input_permit), 40'h0);
      rdc(6'h28, 8'h00, 2'h0);
      report_and_stop();
   end
endmodule
